// ---- design/t2_ops_map.svh ----
/*
  Constants of the timer 2 transfer instruction group: opcodes,
  field positions and reset values.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef T2_OPS_MAP_SVH
`define T2_OPS_MAP_SVH

// Opcodes of the 10-bit instruction word
`define OPC_LOAD_T2_AND_LOW 10'h231
`define OPC_LOAD_HIGH_RELOAD 10'h294
`define OPC_COPY_LOW_TO_T2 10'h295
`define OPC_COPY_B_TO_ACC 10'h01E

// Field positions of an 8-bit byte built from B:A
`define HI_NIBBLE_MSB 7
`define HI_NIBBLE_LSB 4
`define LO_NIBBLE_MSB 3
`define LO_NIBBLE_LSB 0

// Reset values
`define RST_RELOAD 8'h00
`define RST_NIBBLE 4'h0

`endif

// ---- design/t2_ops_pkg.sv ----
/*
  Types shared by the timer 2 transfer instruction block.
  Assumes nothing beyond the constants header.
*/
`include "t2_ops_map.svh"

package t2_ops_pkg;

  // Instructions this block recognises
  typedef enum logic [2:0] {
    op_none,
    op_load_timer2_and_low_reload,
    op_load_timer2_high_reload,
    op_copy_low_reload_to_timer2,
    op_copy_b_to_acc
  } op_type;

  // Register pair B:A, B is the upper nibble
  typedef struct packed {
    logic [3:0] b;
    logic [3:0] a;
  } pair_type;

  // Write strobe with its byte
  typedef struct packed {
    logic we;
    logic [7:0] data;
  } byte_write_type;

endpackage

// ---- design/t2_ops_decode.sv ----
/*
  Opcode decoder of the timer 2 transfer group.
  Assumes the instruction word is stable on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "t2_ops_map.svh"

module t2_ops_decode
  import t2_ops_pkg::*;
(
  // Fetched instruction
  input wire logic [9:0] instr_word,
  input wire logic instr_valid,
  // Decoded operation
  output var op_type op
);

  ////////////////////////////////////////////////////////////////////////
  // Exact match of the whole word, anything else is not ours
  function automatic op_type decode_op(input logic [9:0] w);
    unique case (w)
      `OPC_LOAD_T2_AND_LOW: decode_op = op_load_timer2_and_low_reload;
      `OPC_LOAD_HIGH_RELOAD: decode_op = op_load_timer2_high_reload;
      `OPC_COPY_LOW_TO_T2: decode_op = op_copy_low_reload_to_timer2;
      `OPC_COPY_B_TO_ACC: decode_op = op_copy_b_to_acc;
      default: decode_op = op_none;
    endcase
  endfunction

  // Gate with valid so idle slots decode to nothing
  assign op = instr_valid ? decode_op(instr_word) : op_none;

endmodule
`default_nettype wire

// ---- design/t2_ops_exec.sv ----
/*
  Execute logic of the timer 2 transfer group and the B-to-accumulator
  move. Holds both timer 2 reload registers; drives load strobes to the
  timer 2 counter and the accumulator.
  Assumes the instruction word and A, B come from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "t2_ops_map.svh"

module t2_ops_exec
  import t2_ops_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction from fetch
  input wire logic [9:0] instr_word,
  input wire logic instr_valid,
  // Current register file values
  input wire logic [3:0] acc_value,
  input wire logic [3:0] b_value,
  // Timer 2 counter load
  output var byte_write_type timer2_write,
  // Accumulator load
  output logic acc_we,
  output logic [3:0] acc_data,
  // Reload registers
  output logic [7:0] timer2_low_reload_reg,
  output logic [7:0] timer2_high_reload_reg,
  // Sequencing
  output logic insn_done,
  output logic carry_we,
  output logic skip_next
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  op_type op; // Decoded operation of this cycle
  pair_type pair; // B:A as one byte

  // Opcode decoder
  t2_ops_decode t2_ops_decode_i (
    .instr_word(instr_word),
    .instr_valid(instr_valid),
    .op(op)
  );

  // B upper, A lower
  assign pair.b = b_value;
  assign pair.a = acc_value;

  ////////////////////////////////////////////////////////////////////////
  // Low reload register

  // Written together with the counter, untouched by the copy
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer2_low_reload_reg <= `RST_RELOAD;
    end
    else if (op == op_load_timer2_and_low_reload)
    begin
      // Same byte that goes to the counter
      timer2_low_reload_reg <= pair;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // High reload register

  // Only the high reload write reaches it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer2_high_reload_reg <= `RST_RELOAD;
    end
    else if (op == op_load_timer2_high_reload)
    begin
      // B to the upper nibble
      timer2_high_reload_reg[`HI_NIBBLE_MSB:`HI_NIBBLE_LSB] <= pair.b;
      // A to the lower nibble
      timer2_high_reload_reg[`LO_NIBBLE_MSB:`LO_NIBBLE_LSB] <= pair.a;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer 2 counter load

  // One-cycle strobe with the byte for the counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      timer2_write <= '0;
    end
    else
    begin
      unique case (op)
        // From B:A, same cycle as the low reload write
        op_load_timer2_and_low_reload:
        begin
          timer2_write.we <= 1'b1;
          timer2_write.data <= pair;
        end
        // From the low reload register, bit for bit
        op_copy_low_reload_to_timer2:
        begin
          timer2_write.we <= 1'b1;
          timer2_write.data <= timer2_low_reload_reg;
        end
        // High reload write and the rest leave the counter alone
        op_none, op_load_timer2_high_reload, op_copy_b_to_acc:
        begin
          timer2_write.we <= 1'b0;
          timer2_write.data <= timer2_write.data;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator load

  // B copied into the accumulator
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_we <= 1'b0;
      acc_data <= `RST_NIBBLE;
    end
    else
    begin
      acc_we <= (op == op_copy_b_to_acc);
      if (op == op_copy_b_to_acc)
      begin
        // All four bits of B
        acc_data <= b_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencing

  // Completion pulse; carry and skip are never asserted by this group
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      insn_done <= 1'b0;
      carry_we <= 1'b0;
      skip_next <= 1'b0;
    end
    else
    begin
      // Every instruction of the group ends in one cycle
      insn_done <= (op != op_none);
      carry_we <= 1'b0;
      skip_next <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Opcode words of the group, each qualified by instr_valid
  sequence s_load_both;
    instr_valid && instr_word == `OPC_LOAD_T2_AND_LOW;
  endsequence

  sequence s_load_high;
    instr_valid && instr_word == `OPC_LOAD_HIGH_RELOAD;
  endsequence

  sequence s_copy_low;
    instr_valid && instr_word == `OPC_COPY_LOW_TO_T2;
  endsequence

  sequence s_copy_b;
    instr_valid && instr_word == `OPC_COPY_B_TO_ACC;
  endsequence

  AST_LOAD_BOTH_STROBE: assert property (
    s_load_both |=> timer2_write.we &&
      timer2_write.data == timer2_low_reload_reg)
    else $error("counter and low reload not loaded together");

  AST_LOAD_BOTH_ORDER: assert property (
    s_load_both |=> timer2_write.data == {$past(b_value), $past(acc_value)})
    else $error("B:A nibble order wrong on combined load");

  AST_HIGH_NO_COUNTER: assert property (
    s_load_high |=> !timer2_write.we &&
      $stable(timer2_low_reload_reg))
    else $error("high reload write touched the counter");

  AST_HIGH_UPPER: assert property (
    s_load_high |=> timer2_high_reload_reg[7:4] == $past(b_value))
    else $error("high reload upper nibble is not B");

  AST_HIGH_LOWER: assert property (
    s_load_high |=> timer2_high_reload_reg[3:0] == $past(acc_value))
    else $error("high reload lower nibble is not A");

  AST_COPY_STROBE: assert property (
    s_copy_low |=> timer2_write.we && insn_done)
    else $error("reload copy did not load the counter");

  AST_COPY_VALUE: assert property (
    s_copy_low |=> timer2_write.data == $past(timer2_low_reload_reg) &&
      $stable(timer2_low_reload_reg))
    else $error("reload copy wrong or reload register changed");

  AST_B_TO_ACC: assert property (
    s_copy_b |=> acc_we && acc_data == $past(b_value) && !timer2_write.we)
    else $error("B not copied to the accumulator");

  AST_ONE_CYCLE: assert property (
    instr_valid && (instr_word == `OPC_LOAD_T2_AND_LOW ||
      instr_word == `OPC_LOAD_HIGH_RELOAD ||
      instr_word == `OPC_COPY_LOW_TO_T2 ||
      instr_word == `OPC_COPY_B_TO_ACC) |=>
      insn_done && !carry_we && !skip_next)
    else $error("group instruction not done in one cycle");

  AST_NO_SPURIOUS: assert property (
    !instr_valid |=> !insn_done && !timer2_write.we && !acc_we)
    else $error("write without an instruction");

endmodule
`default_nettype wire

// ---- dv/t2_ops_exec_tb.sv ----
/*
  Self-checking bench of the timer 2 transfer execute block.
  Assumes the package and constants header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "t2_ops_map.svh"

// Compare one value and count it
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module t2_ops_exec_tb
  import t2_ops_pkg::*;
;
  ////////////////////////////////////////////////////////////////////
  // Stimulus and design outputs
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] instr_word = 10'h000;
  logic instr_valid = 1'b0;
  logic [3:0] acc_value = 4'h0;
  logic [3:0] b_value = 4'h0;
  byte_write_type timer2_write;
  logic acc_we;
  logic [3:0] acc_data;
  logic [7:0] timer2_low_reload_reg;
  logic [7:0] timer2_high_reload_reg;
  logic insn_done;
  logic carry_we;
  logic skip_next;
  // Expected state and counters
  logic e_we, e_awe, e_done;
  logic [7:0] e_data, e_low, e_high;
  logic [3:0] e_acc;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  // Near-miss words and opcodes for the corner table
  logic [9:0] corner [8] = '{10'h231, 10'h295, 10'h294, 10'h01E,
                             10'h230, 10'h296, 10'h01F, 10'h21E};

  ////////////////////////////////////////////////////////////////////
  // Design under test
  t2_ops_exec t2_ops_exec_i (
    .clk(clk), .rst(rst), .instr_word(instr_word),
    .instr_valid(instr_valid), .acc_value(acc_value),
    .b_value(b_value), .timer2_write(timer2_write), .acc_we(acc_we),
    .acc_data(acc_data), .timer2_low_reload_reg(timer2_low_reload_reg),
    .timer2_high_reload_reg(timer2_high_reload_reg),
    .insn_done(insn_done), .carry_we(carry_we), .skip_next(skip_next)
  );

  // Clock of 5 ns period
  always #2.5 clk = ~clk;

  // Cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic report_and_stop();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset values of the expected state
  function automatic void model_reset();
    {e_we, e_awe, e_done, e_data, e_low, e_high, e_acc} = '0;
  endfunction

  // Compare every output with the expectation
  task automatic chk_all();
    `CHK(timer2_write.we, e_we)
    `CHK(timer2_write.data, e_data)
    `CHK(timer2_low_reload_reg, e_low)
    `CHK(timer2_high_reload_reg, e_high)
    `CHK(acc_we, e_awe)
    `CHK(acc_data, e_acc)
    `CHK(insn_done, e_done)
    `CHK(carry_we, 1'b0)
    `CHK(skip_next, 1'b0)
  endtask

  // Expected outputs one cycle after this word is taken
  function automatic void predict(input logic [9:0] w, input logic v,
                                  input logic [3:0] a, input logic [3:0] b);
    {e_we, e_awe, e_done} = 3'h0;
    if (v)
    begin
      case (w)
        // Counter and low reload from B:A
        `OPC_LOAD_T2_AND_LOW:
          {e_we, e_data, e_low, e_done} = {1'b1, b, a, b, a, 1'b1};
        // High reload only
        `OPC_LOAD_HIGH_RELOAD: {e_high, e_done} = {b, a, 1'b1};
        // Low reload copied to counter
        `OPC_COPY_LOW_TO_T2: {e_we, e_data, e_done} = {1'b1, e_low, 1'b1};
        // B to accumulator
        `OPC_COPY_B_TO_ACC: {e_awe, e_acc, e_done} = {1'b1, b, 1'b1};
        // Anything else does nothing
        default: e_done = 1'b0;
      endcase
    end
  endfunction

  // Present one word for one cycle, predict, then check
  task automatic step(input logic [9:0] w, input logic v,
                      input logic [3:0] a, input logic [3:0] b);
    instr_word = w;
    instr_valid = v;
    acc_value = a;
    b_value = b;
    predict(w, v, a, b);
    @(posedge clk);
    #1;
    chk_all();
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int r;
    logic [9:0] w;
    void'($urandom(76));
    model_reset();
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk_all();
    // Corner words back to back, each also with valid low
    foreach (corner[i])
      step(corner[i], 1'b1, 4'(i + 5), 4'(15 - i));
    foreach (corner[i])
      step(corner[i], 1'b0, 4'hF, 4'hF);
    // Random mix of opcodes, stray words and idle cycles
    repeat (400)
    begin
      r = $urandom % 6;
      w = (r < 4) ? corner[r] : 10'($urandom);
      step(w, r != 5, 4'($urandom), 4'($urandom));
    end
    // Reset in mid-run clears the reload registers
    rst = 1'b1;
    model_reset();
    #1;
    chk_all();
    @(posedge clk);
    #1;
    rst = 1'b0;
    step(10'h295, 1'b1, 4'hA, 4'h5);
    report_and_stop();
  end
endmodule

`default_nettype wire
